// *** common/eeprom_slave_pkg.sv ***
// constants and types for the two-wire eeprom slave controller
package eeprom_slave_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int ADDR_W = 9;
  localparam int PAGE_W = 4;
  localparam int PAGE_BYTES = 16;
  localparam int DOG_W = 11;
  localparam int BUSY_CNT_W = 20;
  // nonvolatile store time, longest figure, rounded down
  localparam int NV_WRITE_MS = 10;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * (CLK_HZ / 1000);
  localparam int POR_CNT_W = 12;
  localparam logic [POR_CNT_W-1:0] POR_HOLD_CYC = 12'hFA0;
  // slave address byte
  localparam logic [3:0] TYPE_ARRAY = 4'hA;
  localparam logic [3:0] TYPE_CTRL = 4'hB;
  // control register commands
  localparam logic [7:0] CMD_SET_WEL = 8'h02;
  localparam logic [7:0] CMD_SET_REG_WRITE_PERMIT_LATCH = 8'h06;
  localparam logic [7:0] CMD_CLR_WEL = 8'h00;
  // control register bit positions
  localparam int CTL_WD1 = 6;
  localparam int CTL_WD0 = 5;
  localparam int CTL_BP1 = 4;
  localparam int CTL_BP0 = 3;
  localparam int CTL_REG_WRITE_PERMIT_LATCH = 2;
  localparam int CTL_WEL = 1;
  localparam int CTL_BP2 = 0;
  // values after reset
  localparam logic [1:0] WD_RESET = 2'h3;
  localparam logic [2:0] BP_RESET = 3'h0;
  // watchdog periods in ms
  localparam logic [DOG_W-1:0] DOG_00_MS = 11'h578;
  localparam logic [DOG_W-1:0] DOG_01_MS = 11'h258;
  localparam logic [DOG_W-1:0] DOG_10_MS = 11'h0C8;
  // protected region bounds
  localparam logic [ADDR_W-1:0] LOCK_Q4 = 9'h180;
  localparam logic [ADDR_W-1:0] LOCK_HALF = 9'h100;
  localparam logic [ADDR_W-1:0] LOCK_P1 = 9'h010;
  localparam logic [ADDR_W-1:0] LOCK_P2 = 9'h020;
  localparam logic [ADDR_W-1:0] LOCK_P4 = 9'h040;
  localparam logic [ADDR_W-1:0] LOCK_P8 = 9'h080;
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_TXACK, ST_IGNORE, ST_COMMIT, ST_BUSY
  } link_state_t;
endpackage

// *** hdl/two_wire_eeprom_slave_ctrl.sv ***
// two-wire eeprom slave with supervisor control register
// Operation
// - watchdog field: 00 1.4 s, 01 600 ms, 10 200 ms, 11 disabled default
// - write of 02h alone sets the write enable latch, no wait
// - write of 06h sets register write permit and write enable latches
// - third step stores watchdog and lock bits, cycle of at most 10 ms
// - permit latch clears at the stop that starts the nonvolatile control write
// - bit 2 set in third step keeps permit, leaves stored bits alone
// - second data byte to control register aborts write with not-acknowledge
// - reads between sequence steps leave the sequence intact
// - permit clears only on control store, power cycle, locked write attempt
// - start is sda falling with scl high; nothing happens before a start
// - stop is sda rising with scl high; ends every transaction
// - sda moves only while scl low; master clocks, device is slave
// - receiver pulls sda low on ninth clock; wrong address gets silence
// - read continues only while master acknowledges, then waits for stop
// - address byte: type code, two zeros, address msb, direction bit
// - after power-up: standby, write enable clear, sda released
// - byte write acks address and data; stop starts write, inputs ignored
// - data for a locked address is not acknowledged and not written
// - page write increments low four bits, wraps within 16-byte page
// - more than a page of bytes overwrite earlier ones at wrapped addresses
// - stop before one full data byte and ack performs no write
// - with write enable clear only the 02h control byte gets an ack
// - control register reached only with type 1011, one byte per access
// - write guard pin high refuses array and control writes
module two_wire_eeprom_slave_ctrl #(
  parameter int NV_CYC = eeprom_slave_pkg::NV_WRITE_CYC // nonvolatile cycle length
) (
  input wire logic i_sys_clk, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_scl, // serial clock pin
  input wire logic i_sda_in, // serial data pin level
  output logic o_sda_out, // serial data drive value
  output logic o_sda_oe_n, // low while pulling sda
  input wire logic i_write_guard, // high refuses writes
  output logic o_mem_we, // array write strobe
  output logic [eeprom_slave_pkg::ADDR_W-1:0] o_mem_addr, // array address
  output logic [7:0] o_mem_wdata, // array write data
  input wire logic [7:0] i_mem_rdata, // array read data
  output logic [7:0] o_ctrl_reg, // control register image
  output logic o_dog_enable, // watchdog enabled
  output logic [eeprom_slave_pkg::DOG_W-1:0] o_dog_timeout_ms, // watchdog period
  output logic o_write_busy, // internal write cycle
  output logic o_por_hold // power-on hold active
);
  import eeprom_slave_pkg::*;

  // page protection decode
  function automatic logic is_locked(input logic [ADDR_W-1:0] a, input logic [2:0] bp);
    logic r;
    r = 1'b0;
    if (bp == 3'h1) begin
      r = (a >= LOCK_Q4);
    end else if (bp == 3'h2) begin
      r = (a >= LOCK_HALF);
    end else if (bp == 3'h3) begin
      r = 1'b1;
    end else if (bp == 3'h4) begin
      r = (a < LOCK_P1);
    end else if (bp == 3'h5) begin
      r = (a < LOCK_P2);
    end else if (bp == 3'h6) begin
      r = (a < LOCK_P4);
    end else if (bp == 3'h7) begin
      r = (a < LOCK_P8);
    end
    return r;
  endfunction

  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic wg_s1, wg_s2;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  link_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] byte_idx_reg;
  logic is_ctrl_reg, rw_reg, addr_msb_reg, has_data_reg, ack_ok_reg;
  logic master_ack_reg, sda_low_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [7:0] tx_reg, ctrl_data_reg;
  logic [BUSY_CNT_W-1:0] busy_cnt_reg;
  logic [PAGE_W-1:0] cidx_reg;
  logic [7:0] buf_mem [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_reg;
  logic wel_reg, reg_write_permit_latch_reg;
  logic [1:0] wd_reg;
  logic [2:0] bp_reg;
  logic [POR_CNT_W-1:0] por_cnt_reg;
  logic byte_ev, dev_match, wr_open, arr_locked;
  logic data_take, ctrl_take, lock_hit, byte_ack, ctrl_open;
  logic stop_write, commit_ctrl, commit_arr, ctrl_nv;
  logic [7:0] tx_src;

  // two-stage synchronisers plus one history stage
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      wg_s1 <= 1'b0;
      wg_s2 <= 1'b0;
    end else begin
      scl_s1 <= i_scl;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= i_sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      wg_s1 <= i_write_guard;
      wg_s2 <= wg_s1;
    end
  end

  // bus conditions from registered edges
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_ev = scl_s2 && scl_s3 && !sda_s2 && sda_s3;
  assign stop_ev = scl_s2 && scl_s3 && sda_s2 && !sda_s3;

  // byte decode at the falling edge after the eighth bit
  assign byte_ev = scl_fall && (state_reg == ST_RX) && (bit_cnt_reg == 4'h8);
  assign dev_match = ((shift_reg[7:4] == TYPE_ARRAY) || (shift_reg[7:4] == TYPE_CTRL))
                     && (shift_reg[3:2] == 2'h0);
  assign wr_open = wel_reg && !wg_s2;
  // the enabling 02h byte is the one control write taken with the latch clear
  assign ctrl_open = !wg_s2 && (wel_reg || (shift_reg == CMD_SET_WEL));
  assign arr_locked = is_locked(addr_reg, bp_reg);
  assign data_take = byte_ev && (byte_idx_reg == 2'h2) && !is_ctrl_reg && wr_open && !arr_locked;
  assign lock_hit = byte_ev && (byte_idx_reg == 2'h2) && !is_ctrl_reg && wr_open && arr_locked;
  assign ctrl_take = byte_ev && (byte_idx_reg == 2'h2) && is_ctrl_reg && ctrl_open
                     && !has_data_reg;

  // acknowledge decision for the byte just received
  always_comb begin
    if (byte_idx_reg == 2'h0) begin
      byte_ack = dev_match;
    end else if (byte_idx_reg == 2'h1) begin
      byte_ack = 1'b1;
    end else begin
      byte_ack = is_ctrl_reg ? ctrl_take : data_take;
    end
  end

  // write commits only after a whole data byte and its ack; the stop's own scl rise counts one bit
  assign stop_write = stop_ev && (state_reg == ST_RX) && (bit_cnt_reg == 4'h1)
                      && has_data_reg && !rw_reg;
  assign commit_ctrl = stop_write && is_ctrl_reg;
  assign commit_arr = stop_write && !is_ctrl_reg;
  assign ctrl_nv = reg_write_permit_latch_reg && ctrl_data_reg[CTL_WEL] && !ctrl_data_reg[CTL_REG_WRITE_PERMIT_LATCH];
  assign tx_src = is_ctrl_reg ? o_ctrl_reg : i_mem_rdata;

  // serial protocol state machine
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byte_idx_reg <= 2'h0;
      is_ctrl_reg <= 1'b0;
      rw_reg <= 1'b0;
      addr_msb_reg <= 1'b0;
      has_data_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      addr_reg <= '0;
      tx_reg <= 8'h00;
      ctrl_data_reg <= 8'h00;
      busy_cnt_reg <= '0;
      cidx_reg <= '0;
    end else if (state_reg == ST_COMMIT) begin
      cidx_reg <= cidx_reg + 4'h1;
      if (cidx_reg == 4'hF) begin
        state_reg <= ST_BUSY;
        busy_cnt_reg <= '0;
      end
    end else if (state_reg == ST_BUSY) begin
      busy_cnt_reg <= busy_cnt_reg + 20'h00001; // inputs ignored
      if (busy_cnt_reg == BUSY_CNT_W'(NV_CYC - 1)) begin
        state_reg <= ST_IDLE;
      end
    end else if (start_ev) begin
      state_reg <= ST_RX;
      bit_cnt_reg <= 4'h0;
      byte_idx_reg <= 2'h0;
      has_data_reg <= 1'b0;
      sda_low_reg <= 1'b0;
    end else if (stop_ev) begin
      sda_low_reg <= 1'b0;
      if (commit_arr) begin
        state_reg <= ST_COMMIT;
        cidx_reg <= '0;
      end else if (commit_ctrl && ctrl_nv) begin
        state_reg <= ST_BUSY;
        busy_cnt_reg <= '0;
      end else begin
        state_reg <= ST_IDLE;
      end
    end else begin
      case (state_reg)
        ST_RX: begin
          if (scl_rise && (bit_cnt_reg != 4'h8)) begin
            shift_reg <= {shift_reg[6:0], sda_s2};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_ev) begin
            ack_ok_reg <= byte_ack;
            sda_low_reg <= byte_ack;
            bit_cnt_reg <= 4'h0;
            state_reg <= ST_ACK;
            if (byte_idx_reg == 2'h0) begin
              is_ctrl_reg <= shift_reg[4];
              addr_msb_reg <= shift_reg[1];
              rw_reg <= shift_reg[0];
              byte_idx_reg <= 2'h1;
            end else if (byte_idx_reg == 2'h1) begin
              addr_reg <= {addr_msb_reg, shift_reg};
              byte_idx_reg <= 2'h2;
            end else begin
              if (data_take) begin
                addr_reg[PAGE_W-1:0] <= addr_reg[PAGE_W-1:0] + 4'h1;
              end
              if (ctrl_take) begin
                ctrl_data_reg <= shift_reg;
              end
              if (byte_ack) begin
                has_data_reg <= 1'b1;
              end
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_low_reg <= 1'b0;
            if (!ack_ok_reg) begin
              state_reg <= ST_IGNORE;
            end else if (rw_reg && (byte_idx_reg == 2'h1)) begin
              state_reg <= ST_TX;
              tx_reg <= tx_src;
              sda_low_reg <= !tx_src[7];
              if (!is_ctrl_reg) begin
                addr_reg <= addr_reg + 9'h001;
              end
            end else begin
              state_reg <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= ST_TXACK;
              sda_low_reg <= 1'b0;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_low_reg <= !tx_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_TXACK: begin
          if (scl_rise) begin
            master_ack_reg <= !sda_s2;
          end
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (master_ack_reg && !is_ctrl_reg) begin
              state_reg <= ST_TX;
              tx_reg <= tx_src;
              sda_low_reg <= !tx_src[7];
              addr_reg <= addr_reg + 9'h001;
            end else begin
              state_reg <= ST_IGNORE;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // page buffer, later bytes replace earlier ones at wrapped slots
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      valid_reg <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        buf_mem[i] <= 8'h00;
      end
    end else if ((state_reg == ST_COMMIT) && (cidx_reg == 4'hF)) begin
      valid_reg <= '0;
    end else if (start_ev && (state_reg != ST_COMMIT) && (state_reg != ST_BUSY)) begin
      valid_reg <= '0;
    end else if (data_take) begin
      buf_mem[addr_reg[PAGE_W-1:0]] <= shift_reg;
      valid_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // array write port, one strobe per buffered byte
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_we <= 1'b0;
      o_mem_addr <= '0;
      o_mem_wdata <= 8'h00;
    end else if (state_reg == ST_COMMIT) begin
      o_mem_we <= valid_reg[cidx_reg];
      o_mem_addr <= {addr_reg[ADDR_W-1:PAGE_W], cidx_reg};
      o_mem_wdata <= buf_mem[cidx_reg];
    end else begin
      o_mem_we <= 1'b0;
      o_mem_addr <= addr_reg;
    end
  end

  // control register latches and nonvolatile bits
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wel_reg <= 1'b0;
      reg_write_permit_latch_reg <= 1'b0;
      wd_reg <= WD_RESET;
      bp_reg <= BP_RESET;
    end else if (lock_hit) begin
      reg_write_permit_latch_reg <= 1'b0;
    end else if (commit_ctrl) begin
      if (ctrl_nv) begin
        wd_reg <= {ctrl_data_reg[CTL_WD1], ctrl_data_reg[CTL_WD0]};
        bp_reg <= {ctrl_data_reg[CTL_BP2], ctrl_data_reg[CTL_BP1], ctrl_data_reg[CTL_BP0]};
        reg_write_permit_latch_reg <= 1'b0;
      end else if (ctrl_data_reg == CMD_SET_REG_WRITE_PERMIT_LATCH) begin
        reg_write_permit_latch_reg <= 1'b1;
        wel_reg <= 1'b1;
      end else if (ctrl_data_reg == CMD_SET_WEL) begin
        wel_reg <= 1'b1;
      end else if (ctrl_data_reg == CMD_CLR_WEL) begin
        wel_reg <= 1'b0;
      end
    end
  end

  // watchdog period decode
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_dog_enable <= 1'b0;
      o_dog_timeout_ms <= '0;
    end else begin
      o_dog_enable <= (wd_reg != 2'h3);
      case (wd_reg)
        2'h0: o_dog_timeout_ms <= DOG_00_MS;
        2'h1: o_dog_timeout_ms <= DOG_01_MS;
        2'h2: o_dog_timeout_ms <= DOG_10_MS;
        default: o_dog_timeout_ms <= '0;
      endcase
    end
  end

  // power-on hold counter
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      por_cnt_reg <= '0;
      o_por_hold <= 1'b1;
    end else if (por_cnt_reg != POR_HOLD_CYC) begin
      por_cnt_reg <= por_cnt_reg + 12'h001;
    end else begin
      o_por_hold <= 1'b0;
    end
  end

  // pin and status outputs
  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = !sda_low_reg; // released while busy
  assign o_write_busy = (state_reg == ST_COMMIT) || (state_reg == ST_BUSY);
  assign o_ctrl_reg = {1'b0, wd_reg, bp_reg[1], bp_reg[0], reg_write_permit_latch_reg, wel_reg, bp_reg[2]};
endmodule

// *** verification/two_wire_eeprom_slave_ctrl_properties.sv ***
// port checks for the two-wire eeprom slave controller
module eeprom_slave_properties #(
  parameter int NV_CYC = eeprom_slave_pkg::NV_WRITE_CYC // store length
) (
  input wire logic i_sys_clk, // clock
  input wire logic i_rstn, // reset
  input wire logic i_scl, // bus clock
  input wire logic i_sda_in, // bus data
  input wire logic o_sda_out, // drive value
  input wire logic o_sda_oe_n, // pull enable
  input wire logic i_write_guard, // guard pin
  input wire logic o_mem_we, // write strobe
  input wire logic [eeprom_slave_pkg::ADDR_W-1:0] o_mem_addr, // address
  input wire logic [7:0] o_mem_wdata, // write data
  input wire logic [7:0] i_mem_rdata, // read data
  input wire logic [7:0] o_ctrl_reg, // control image
  input wire logic o_dog_enable, // dog on
  input wire logic [eeprom_slave_pkg::DOG_W-1:0] o_dog_timeout_ms, // period
  input wire logic o_write_busy, // busy
  input wire logic o_por_hold // hold
);
  import eeprom_slave_pkg::*;
  logic [BUSY_CNT_W-1:0] busy_run_reg;
  // watchdog period per field value
  function automatic logic [DOG_W-1:0] dog_ms(input logic [1:0] wd);
    case (wd)
      2'h0: return DOG_00_MS;
      2'h1: return DOG_01_MS;
      2'h2: return DOG_10_MS;
      default: return '0;
    endcase
  endfunction
  // locked region per lock select
  function automatic logic locked(input logic [8:0] a, input logic [2:0] bp);
    case (bp)
      3'h1: return a >= LOCK_Q4;
      3'h2: return a >= LOCK_HALF;
      3'h3: return 1'b1;
      3'h4: return a < LOCK_P1;
      3'h5: return a < LOCK_P2;
      3'h6: return a < LOCK_P4;
      3'h7: return a < LOCK_P8;
      default: return 1'b0;
    endcase
  endfunction
  // length of the current busy run
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_run_reg <= '0;
    end else begin
      busy_run_reg <= o_write_busy ? busy_run_reg + 1'b1 : '0;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sda_value_low_a: assert property (o_sda_out == 1'b0) else $error("sda value not low");
  reset_image_a: assert property ($rose(i_rstn) |-> o_ctrl_reg == 8'h60 && o_sda_oe_n)
    else $error("bad state after reset");
  dog_map_a: assert property (o_dog_timeout_ms == dog_ms($past(o_ctrl_reg[6:5]))
    && o_dog_enable == ($past(o_ctrl_reg[6:5]) != 2'h3)) else $error("watchdog period wrong");
  ctrl_msb_zero_a: assert property (o_ctrl_reg[7] == 1'b0) else $error("control bit 7 set");
  we_in_busy_a: assert property (o_mem_we |-> o_write_busy) else $error("write outside cycle");
  busy_released_a: assert property (o_write_busy |-> o_sda_oe_n) else $error("sda pulled while busy");
  lock_respect_a: assert property (o_mem_we |->
    !locked(o_mem_addr, {o_ctrl_reg[0], o_ctrl_reg[4], o_ctrl_reg[3]})) else $error("locked byte written");
  wel_needed_a: assert property (o_mem_we |-> o_ctrl_reg[1]) else $error("write without enable");
  page_step_a: assert property (o_mem_we && $past(o_mem_we) |->
    o_mem_addr == {$past(o_mem_addr[8:4]), $past(o_mem_addr[3:0]) + 4'h1}) else $error("page step wrong");
  nv_length_a: assert property ($fell(o_write_busy) |-> busy_run_reg >= NV_CYC)
    else $error("store cycle too short");
  nv_bound_a: assert property (busy_run_reg <= NV_CYC + 17) else $error("store cycle too long");
  cover property (o_mem_we);
  cover property ($fell(o_write_busy));
  cover property ($fell(o_sda_oe_n));
endmodule
bind two_wire_eeprom_slave_ctrl eeprom_slave_properties #(.NV_CYC(NV_CYC)) u_eeprom_slave_properties (
  .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_sda_in(i_sda_in), .o_sda_out(o_sda_out),
  .o_sda_oe_n(o_sda_oe_n), .i_write_guard(i_write_guard), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr),
  .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .o_ctrl_reg(o_ctrl_reg), .o_dog_enable(o_dog_enable),
  .o_dog_timeout_ms(o_dog_timeout_ms), .o_write_busy(o_write_busy), .o_por_hold(o_por_hold));

// *** verification/bus_master.sv ***
// two-wire bus master model, 8 system clocks per bus bit
module bus_master (
  input wire logic i_clk, // pacing clock
  input wire logic i_sda_wire, // resolved sda
  output logic o_scl, // bus clock
  output logic o_sda // 1 releases sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // bus idles high
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // start or repeated start
  task automatic bus_start();
    tick(2);
    o_sda = 1'b1;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b0;
    tick(4);
    o_scl = 1'b0;
  endtask
  task automatic bus_stop();
    tick(2);
    o_sda = 1'b0;
    tick(2);
    o_scl = 1'b1;
    tick(4);
    o_sda = 1'b1;
    tick(4);
  endtask
  // one bit, sda moved only in the low phase
  task automatic bit_cycle(input logic b, output logic seen);
    tick(2);
    o_sda = b;
    tick(2);
    o_scl = 1'b1;
    tick(2);
    seen = i_sda_wire;
    tick(2);
    o_scl = 1'b0;
  endtask
  // byte out msb first, sda released on the ninth clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = !s;
  endtask
  task automatic recv_byte(output logic [7:0] b, input logic ack_m);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
    bit_cycle(!ack_m, s);
  endtask
endmodule

// *** verification/testbench.sv ***
// self-checking bench for the two-wire eeprom slave controller
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import eeprom_slave_pkg::*;
  localparam int NV = 20;
  logic clk, rstn, guard, sda_wire, m_scl, m_sda, sda_out, oe_n, we, dog_en, busy, por, ack;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, ctrl;
  logic [DOG_W-1:0] dog_ms;
  logic [7:0] mem [512];
  logic [7:0] exp_mem [512];
  logic [7:0] wbuf [32];
  logic [7:0] rbuf [32];
  logic [DOG_W-1:0] ms_tab [4] = '{DOG_00_MS, DOG_01_MS, DOG_10_MS, '0};
  int miscompares, total_checks, we_count;
  assign sda_wire = oe_n ? m_sda : 1'b0;
  assign rdata = mem[addr];
  two_wire_eeprom_slave_ctrl #(.NV_CYC(NV)) u_two_wire_eeprom_slave_ctrl (.i_sys_clk(clk), .i_rstn(rstn),
    .i_scl(m_scl), .i_sda_in(sda_wire), .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .i_write_guard(guard),
    .o_mem_we(we), .o_mem_addr(addr), .o_mem_wdata(wdata), .i_mem_rdata(rdata), .o_ctrl_reg(ctrl),
    .o_dog_enable(dog_en), .o_dog_timeout_ms(dog_ms), .o_write_busy(busy), .o_por_hold(por));
  bus_master u_bus_master (.i_clk(clk), .i_sda_wire(sda_wire), .o_scl(m_scl), .o_sda(m_sda));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // array model behind the memory port
  always @(posedge clk) begin
    if (we === 1'b1) begin
      mem[addr] <= wdata;
      we_count <= we_count + 1;
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // write of n bytes from wbuf; bytes from index nack_at on are refused
  task automatic wr(input logic [3:0] t, input logic [8:0] a, input int n, input int nack_at);
    int k;
    u_bus_master.bus_start();
    u_bus_master.send_byte({t, 2'b00, a[8], 1'b0}, ack);
    check(ack, 1'b1);
    u_bus_master.send_byte(a[7:0], ack);
    check(ack, 1'b1);
    for (k = 0; k < n; k++) begin
      u_bus_master.send_byte(wbuf[k], ack);
      check(ack, k < nack_at);
    end
    u_bus_master.bus_stop();
    for (k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge clk);
    check(busy, 1'b0);
  endtask
  // random read of n bytes into rbuf
  task automatic rd(input logic [3:0] t, input logic [8:0] a, input int n);
    u_bus_master.bus_start();
    u_bus_master.send_byte({t, 2'b00, a[8], 1'b0}, ack);
    u_bus_master.send_byte(a[7:0], ack);
    u_bus_master.bus_start();
    u_bus_master.send_byte({t, 2'b00, a[8], 1'b1}, ack);
    check(ack, 1'b1);
    for (int k = 0; k < n; k++) u_bus_master.recv_byte(rbuf[k], k < n - 1);
    u_bus_master.bus_stop();
  endtask
  task automatic rd_cmp(input logic [8:0] a, input int n);
    rd(TYPE_ARRAY, a, n);
    for (int k = 0; k < n; k++) check(rbuf[k], exp_mem[a + k]);
  endtask
  task automatic ctrl_wr(input logic [7:0] v, input int nack_at);
    wbuf[0] = v;
    wr(TYPE_CTRL, 9'h1FF, 1, nack_at);
  endtask
  // full three-step control change
  task automatic ctrl_seq(input logic [7:0] v);
    ctrl_wr(CMD_SET_WEL, 1);
    ctrl_wr(CMD_SET_REG_WRITE_PERMIT_LATCH, 1);
    check(ctrl[2:1], 2'b11);
    ctrl_wr(v, 1);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    rstn = 1'b0;
    guard = 1'b0;
    we_count = 0;
    for (int i = 0; i < 512; i++) mem[i] = 8'hFF;
    for (int i = 0; i < 512; i++) exp_mem[i] = 8'hFF;
    repeat (3) @(negedge clk);
    check({oe_n, por, dog_en, busy, ctrl}, 16'h0C60);
    rstn = 1'b1;
    u_bus_master.tick(8);
    $display("reset test done");
    wbuf[0] = 8'h55;
    wr(TYPE_ARRAY, 9'h005, 1, 0);
    ctrl_wr(CMD_SET_REG_WRITE_PERMIT_LATCH, 0);
    check(ctrl, 8'h60);
    foreach (wbuf[i]) wbuf[i] = (i % 2) ? 8'hC0 : 8'hA4;
    for (int i = 0; i < 2; i++) begin
      u_bus_master.bus_start();
      u_bus_master.send_byte(wbuf[i], ack);
      check(ack, 1'b0);
      u_bus_master.bus_stop();
    end
    ctrl_wr(CMD_SET_WEL, 1);
    check(ctrl, 8'h62);
    $display("refusal test done");
    for (int k = 0; k < 18; k++) begin
      wbuf[k] = 8'h30 + k;
      exp_mem[{5'h10, 4'(10 + k)}] = wbuf[k];
    end
    wr(TYPE_ARRAY, 9'h10A, 18, 18);
    check(we_count, 16);
    rd_cmp(9'h100, 16);
    wr(TYPE_ARRAY, 9'h005, 0, 0);
    check(we_count, 16);
    $display("page test done");
    for (int i = 0; i < 4; i++) begin
      ctrl_wr(CMD_SET_WEL, 1);
      ctrl_wr(CMD_SET_REG_WRITE_PERMIT_LATCH, 1);
      rd(TYPE_CTRL, 9'h1FF, 1);
      check(rbuf[0], (i == 0) ? 8'h66 : {1'b0, 2'(i - 1), 5'b00110});
      ctrl_wr({1'b0, 2'(i), 5'b00010}, 1);
      check(ctrl, {1'b0, 2'(i), 5'b00010});
      check({dog_en, dog_ms}, {i != 3, ms_tab[i]});
    end
    ctrl_wr(8'h4A, 1);
    check(ctrl, 8'h62);
    ctrl_seq(8'h4A);
    check(ctrl, 8'h4A);
    ctrl_seq(8'h0E);
    check(ctrl, 8'h4E);
    wbuf[0] = CMD_SET_WEL;
    wbuf[1] = CMD_SET_WEL;
    wr(TYPE_CTRL, 9'h1FF, 2, 1);
    check(ctrl, 8'h4E);
    wbuf[0] = 8'h77;
    wr(TYPE_ARRAY, 9'h1F0, 1, 0);
    check(ctrl, 8'h4A);
    rd_cmp(9'h1F0, 1);
    $display("control test done");
    wbuf[0] = 8'h5A;
    exp_mem[9'h050] = 8'h5A;
    wr(TYPE_ARRAY, 9'h050, 1, 1);
    guard = 1'b1;
    wbuf[0] = 8'hA5;
    wr(TYPE_ARRAY, 9'h060, 1, 0);
    ctrl_wr(CMD_CLR_WEL, 0);
    check(ctrl, 8'h4A);
    guard = 1'b0;
    rd_cmp(9'h050, 17);
    check({por, busy}, 2'b00);
    $display("guard test done");
    test_done();
  end
endmodule
